/* File: ger_pkg.sv */
`default_nettype none

package ger_pkg;

   // ---------------------------------------------------------------
   // Error flag layout
   // ---------------------------------------------------------------
   localparam int unsigned ERR_W = 8;
   localparam int unsigned BIT_CMDQ = 0;
   localparam int unsigned BIT_EVENTQ_ABT = 1;
   localparam int unsigned BIT_PRIQ_ABT = 2;
   localparam int unsigned BIT_SYNC_MSG = 3;
   localparam int unsigned BIT_EVENT_MSG = 4;
   localparam int unsigned BIT_PRIQ_MSG = 5;
   localparam int unsigned BIT_ERR_MSG = 6;
   localparam int unsigned BIT_FAILURE = 7;
   localparam logic [7:0] IMPL_MASK_NS = 8'hff;
   localparam logic [7:0] IMPL_MASK_S = 8'hdf;
   localparam logic [7:0] NOTIFY_MASK = 8'hbf;
   localparam logic [7:0] ERR_MSG_ONE = 8'h40;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned BANK_SEL_BIT = 6;
   localparam logic [7:0] OFF_FLAGS = 8'h00;
   localparam logic [7:0] OFF_ACK = 8'h04;
   localparam logic [7:0] OFF_IRQ_CTRL = 8'h08;
   localparam logic [7:0] OFF_CFG0 = 8'h0c;
   localparam logic [7:0] OFF_CFG1 = 8'h10;
   localparam logic [7:0] OFF_CFG2 = 8'h14;
   localparam logic [7:0] OFF_INT_STATUS = 8'h80;
   localparam logic [7:0] OFF_INT_MASK = 8'h84;
   localparam int unsigned IRQEN_BIT = 0;
   localparam int unsigned MSI_MODE_BIT = 1;
   localparam int unsigned INT_W = 2;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [7:0] RST_BYTE = 8'h00;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic priq_msg_abt;
      logic event_msg_abt;
      logic sync_msg_abt;
      logic priq_abt;
      logic eventq_abt;
      logic command_queue_error;
   } ger_err_t;

   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic [31:0] data;
      logic [31:0] attr;
   } ger_msi_t;

   typedef enum logic {
      MSI_IDLE = 1'b0,
      MSI_SEND = 1'b1
   } ger_msi_state_t;

endpackage

`default_nettype wire

/* File: ger_bank.sv */
`timescale 1ns/1ps
`default_nettype none

module ger_bank #(
   parameter logic [7:0] IMPL_MASK = 8'hff
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] evt_i,
   input wire logic ack_we_i,
   input wire logic [7:0] ack_wdata_i,
   output logic [7:0] flags_o,
   output logic [7:0] ack_o,
   output logic [7:0] active_o,
   output logic notify_o
);

   logic [7:0] flags_reg;
   logic [7:0] ack_reg;
   logic [7:0] active_reg;
   logic [7:0] toggle;
   logic [7:0] flags_next;
   logic [7:0] ack_next;

   // ---------------------------------------------------------------
   // Toggle handshake
   // ---------------------------------------------------------------
   // Active bits are masked so repeats before acknowledgement are dropped.
   assign toggle = evt_i & IMPL_MASK & ~active_reg;
   assign flags_next = flags_reg ^ toggle;
   assign ack_next = ack_we_i ? (ack_wdata_i & IMPL_MASK) : ack_reg;
   assign notify_o = |(toggle & ger_pkg::NOTIFY_MASK);

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         flags_reg <= ger_pkg::RST_BYTE;
         ack_reg <= ger_pkg::RST_BYTE;
         active_reg <= ger_pkg::RST_BYTE;
      end
      else
      begin
         flags_reg <= flags_next;
         ack_reg <= ack_next;
         active_reg <= flags_next ^ ack_next;
      end
   end

   assign flags_o = flags_reg;
   assign ack_o = ack_reg;
   assign active_o = active_reg;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   chk_active_match: assert property (active_o == (flags_o ^ ack_o))
      else $error("active bits differ from flag xor acknowledge");
   chk_flag_toggles: assert property ((evt_i & IMPL_MASK & ~active_o) != 8'h00
      |=> flags_o != $past(flags_o))
      else $error("new error did not toggle its flag");
   chk_no_retoggle: assert property (##1
      (((flags_o ^ $past(flags_o)) & $past(active_o)) == 8'h00))
      else $error("active error toggled again");
   chk_ack_quiet: assert property (ack_we_i && evt_i == 8'h00
      |=> flags_o == $past(flags_o) && !$past(notify_o))
      else $error("acknowledge write changed a flag");
   chk_absent_bit: assert property ((flags_o & ~IMPL_MASK) == 8'h00)
      else $error("unimplemented flag bit set");
   chk_errmsg_quiet: assert property (
      (evt_i & IMPL_MASK & ~active_o) == ger_pkg::ERR_MSG_ONE |-> !notify_o)
      else $error("error message abort raised a notification");

endmodule

`default_nettype wire

/* File: ger_top.sv */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Programming-interface errors go into the bank's flag register, never the event queue.
// - Flags cover command queue, two queue aborts, four message aborts, failure mode.
// - A triggered error is activated by inverting its flag bit.
// - An error is active while its flag and acknowledge bits differ.
// - An active error is not toggled again; repeats before acknowledgement are dropped.
// - Command queue consumption halts while the command queue error is active.
// - Event queue delivery stops once its access abort is flagged.
// - Page request queue delivery stops once its access abort is flagged.
// - Failure mode entry raises the failure flag in both banks.
// - The page request message abort flag exists only in the non-secure bank.
// - Every activation raises the interrupt, except the error message abort.
// - The error interrupt fires only while its enable bit is one.
// - Message interrupts take address, data, attributes from config registers zero to two.
// - Simultaneous activations may merge into one interrupt.
// - Flag updates never wait for the interrupt to become visible.

module ger_top (
   input wire logic MCLK_I,
   input wire logic RESET_N_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire ger_pkg::ger_err_t ERR_NS_I,
   input wire ger_pkg::ger_err_t ERR_S_I,
   input wire logic FAILURE_ENTRY_I,
   output logic [1:0] CMDQ_HALT_O,
   output logic [1:0] EVENTQ_HALT_O,
   output logic [1:0] PRIQ_HALT_O,
   output ger_pkg::ger_msi_t MSI_NS_O,
   output ger_pkg::ger_msi_t MSI_S_O,
   input wire logic [1:0] MSI_DONE_I,
   input wire logic [1:0] MSI_ABORT_I,
   output logic IRQ_O
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [7:0] evt [2];
   logic [7:0] flags [2];
   logic [7:0] ack [2];
   logic [7:0] active [2];
   logic [1:0] notify;
   logic [1:0] ack_we;
   logic [1:0] irq_ctrl_reg [2];
   logic [31:0] cfg_reg [2][3];
   logic [1:0] trig;
   logic [1:0] pend_reg;
   logic [1:0] abort_reg;
   ger_pkg::ger_msi_state_t msi_state_reg [2];
   ger_pkg::ger_msi_t msi_reg [2];
   logic [ger_pkg::INT_W-1:0] int_status_reg;
   logic [ger_pkg::INT_W-1:0] int_mask_reg;
   logic [ger_pkg::INT_W-1:0] int_set;
   logic [ger_pkg::INT_W-1:0] int_clr;
   logic [ger_pkg::INT_W-1:0] int_status_next;
   logic [ger_pkg::INT_W-1:0] int_mask_next;
   logic irq_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] rd_data;
   logic rd_hit;
   logic setup;
   logic access;
   logic wr_acc;
   logic bsel;
   logic [7:0] boff;

   // ---------------------------------------------------------------
   // Error sources
   // ---------------------------------------------------------------
   // The failure mode input feeds both banks; the error message abort comes
   // from this block's own message sender, one cycle after the abort.
   assign evt[0] = {FAILURE_ENTRY_I, abort_reg[0], ERR_NS_I};
   assign evt[1] = {FAILURE_ENTRY_I, abort_reg[1], ERR_S_I};

   ger_bank #(
      .IMPL_MASK(ger_pkg::IMPL_MASK_NS)
   ) u_bank_ns (
      .clk_i(MCLK_I),
      .rst_n_i(RESET_N_I),
      .evt_i(evt[0]),
      .ack_we_i(ack_we[0]),
      .ack_wdata_i(PWDATA_I[7:0]),
      .flags_o(flags[0]),
      .ack_o(ack[0]),
      .active_o(active[0]),
      .notify_o(notify[0])
   );

   ger_bank #(
      .IMPL_MASK(ger_pkg::IMPL_MASK_S)
   ) u_bank_s (
      .clk_i(MCLK_I),
      .rst_n_i(RESET_N_I),
      .evt_i(evt[1]),
      .ack_we_i(ack_we[1]),
      .ack_wdata_i(PWDATA_I[7:0]),
      .flags_o(flags[1]),
      .ack_o(ack[1]),
      .active_o(active[1]),
      .notify_o(notify[1])
   );

   // ---------------------------------------------------------------
   // Queue halts
   // ---------------------------------------------------------------
   // Halts follow the registered active bits, so they clear the cycle after
   // software writes the matching acknowledge value.
   assign CMDQ_HALT_O = {active[1][ger_pkg::BIT_CMDQ], active[0][ger_pkg::BIT_CMDQ]};
   assign EVENTQ_HALT_O = {active[1][ger_pkg::BIT_EVENTQ_ABT],
                           active[0][ger_pkg::BIT_EVENTQ_ABT]};
   assign PRIQ_HALT_O = {active[1][ger_pkg::BIT_PRIQ_ABT],
                         active[0][ger_pkg::BIT_PRIQ_ABT]};

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   // One fixed wait-free answer: ready is raised in the access phase so that
   // every output comes from a flip-flop.
   assign setup = PSEL_I & ~PENABLE_I & ~pready_reg;
   assign access = PSEL_I & PENABLE_I & pready_reg;
   assign wr_acc = access & PWRITE_I;
   assign bsel = PADDR_I[ger_pkg::BANK_SEL_BIT];
   assign boff = {2'b00, PADDR_I[5:0]};

   always_comb
   begin
      rd_data = ger_pkg::RST_WORD;
      rd_hit = 1'b0;
      if (PADDR_I == ger_pkg::OFF_INT_STATUS)
      begin
         rd_data = {30'h0000_0000, int_status_reg};
         rd_hit = 1'b1;
      end
      else if (PADDR_I == ger_pkg::OFF_INT_MASK)
      begin
         rd_data = {30'h0000_0000, int_mask_reg};
         rd_hit = 1'b1;
      end
      else if (!PADDR_I[7])
      begin
         rd_hit = 1'b1;
         unique case (boff)
            ger_pkg::OFF_FLAGS: rd_data = {24'h00_0000, flags[bsel]};
            ger_pkg::OFF_ACK: rd_data = {24'h00_0000, ack[bsel]};
            ger_pkg::OFF_IRQ_CTRL: rd_data = {30'h0000_0000, irq_ctrl_reg[bsel]};
            ger_pkg::OFF_CFG0: rd_data = cfg_reg[bsel][0];
            ger_pkg::OFF_CFG1: rd_data = cfg_reg[bsel][1];
            ger_pkg::OFF_CFG2: rd_data = cfg_reg[bsel][2];
            default: rd_hit = 1'b0;
         endcase
      end
   end

   always_ff @(posedge MCLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         prdata_reg <= ger_pkg::RST_WORD;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         pready_reg <= setup;
         pslverr_reg <= setup & ~rd_hit;
         prdata_reg <= (setup & ~PWRITE_I) ? rd_data : ger_pkg::RST_WORD;
      end
   end

   assign PRDATA_O = prdata_reg;
   assign PREADY_O = pready_reg;
   assign PSLVERR_O = pslverr_reg;

   // Flags have no write path; of the flag and acknowledge words only the acknowledge word takes writes.
   always_comb
   begin
      ack_we = 2'b00;
      if (wr_acc && !PADDR_I[7] && boff == ger_pkg::OFF_ACK)
      begin
         ack_we[bsel] = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Interrupt control and message configuration
   // ---------------------------------------------------------------
   always_ff @(posedge MCLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         for (int b = 0; b < 2; b++)
         begin
            irq_ctrl_reg[b] <= 2'b00;
            for (int c = 0; c < 3; c++)
            begin
               cfg_reg[b][c] <= ger_pkg::RST_WORD;
            end
         end
      end
      else if (wr_acc && !PADDR_I[7])
      begin
         unique case (boff)
            ger_pkg::OFF_IRQ_CTRL: irq_ctrl_reg[bsel] <= PWDATA_I[1:0];
            ger_pkg::OFF_CFG0: cfg_reg[bsel][0] <= PWDATA_I;
            ger_pkg::OFF_CFG1: cfg_reg[bsel][1] <= PWDATA_I;
            ger_pkg::OFF_CFG2: cfg_reg[bsel][2] <= PWDATA_I;
            default:
            begin
            end
         endcase
      end
   end

   // A notification is dropped, not deferred, while the enable is zero.
   always_comb
   begin
      for (int b = 0; b < 2; b++)
      begin
         trig[b] = notify[b] & irq_ctrl_reg[b][ger_pkg::IRQEN_BIT];
      end
   end

   // ---------------------------------------------------------------
   // Message sender
   // ---------------------------------------------------------------
   // Pending is one bit per bank, so activations arriving while a send
   // is in progress merge into a single following message.
   always_ff @(posedge MCLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         pend_reg <= 2'b00;
         abort_reg <= 2'b00;
         for (int b = 0; b < 2; b++)
         begin
            msi_state_reg[b] <= ger_pkg::MSI_IDLE;
            msi_reg[b] <= '0;
         end
      end
      else
      begin
         for (int b = 0; b < 2; b++)
         begin
            abort_reg[b] <= 1'b0;
            unique case (msi_state_reg[b])
               ger_pkg::MSI_IDLE:
               begin
                  if (pend_reg[b])
                  begin
                     msi_state_reg[b] <= ger_pkg::MSI_SEND;
                     msi_reg[b].valid <= 1'b1;
                     msi_reg[b].addr <= cfg_reg[b][0];
                     msi_reg[b].data <= cfg_reg[b][1];
                     msi_reg[b].attr <= cfg_reg[b][2];
                  end
                  pend_reg[b] <= trig[b] & irq_ctrl_reg[b][ger_pkg::MSI_MODE_BIT];
               end
               ger_pkg::MSI_SEND:
               begin
                  if (MSI_DONE_I[b])
                  begin
                     msi_state_reg[b] <= ger_pkg::MSI_IDLE;
                     msi_reg[b].valid <= 1'b0;
                     abort_reg[b] <= MSI_ABORT_I[b];
                  end
                  pend_reg[b] <= pend_reg[b] |
                                 (trig[b] & irq_ctrl_reg[b][ger_pkg::MSI_MODE_BIT]);
               end
            endcase
         end
      end
   end

   assign MSI_NS_O = msi_reg[0];
   assign MSI_S_O = msi_reg[1];

   // ---------------------------------------------------------------
   // Wired interrupt status
   // ---------------------------------------------------------------
   // Only bits that were actually returned are cleared, so a set landing
   // between the sample and the read completion is kept.
   always_comb
   begin
      for (int b = 0; b < 2; b++)
      begin
         int_set[b] = trig[b] & ~irq_ctrl_reg[b][ger_pkg::MSI_MODE_BIT];
      end
      int_clr = (access && !PWRITE_I && PADDR_I == ger_pkg::OFF_INT_STATUS) ?
                prdata_reg[ger_pkg::INT_W-1:0] : 2'b00;
      int_status_next = (int_status_reg & ~int_clr) | int_set;
      int_mask_next = (wr_acc && PADDR_I == ger_pkg::OFF_INT_MASK) ?
                      PWDATA_I[ger_pkg::INT_W-1:0] : int_mask_reg;
   end

   always_ff @(posedge MCLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         int_status_reg <= 2'b00;
         int_mask_reg <= 2'b00;
         irq_reg <= 1'b0;
      end
      else
      begin
         int_status_reg <= int_status_next;
         int_mask_reg <= int_mask_next;
         irq_reg <= |(int_status_next & int_mask_next);
      end
   end

   assign IRQ_O = irq_reg;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (!RESET_N_I);

   chk_cmdq_halt: assert property (CMDQ_HALT_O[0] == (flags[0][0] ^ ack[0][0]) &&
      CMDQ_HALT_O[1] == (flags[1][0] ^ ack[1][0]))
      else $error("command queue halt disagrees with flag state");
   chk_queue_stop: assert property ($rose(EVENTQ_HALT_O[0]) || $rose(PRIQ_HALT_O[0])
      |-> $past(ERR_NS_I.eventq_abt) || $past(ERR_NS_I.priq_abt))
      else $error("queue halt rose without an abort");
   chk_failure_both: assert property (
      FAILURE_ENTRY_I && !active[0][7] && !active[1][7] |=> active[0][7] && active[1][7])
      else $error("failure mode not flagged in both banks");
   chk_irq_gate: assert property ($rose(int_status_reg[0])
      |-> $past(notify[0]) && $past(irq_ctrl_reg[0]) == 2'b01)
      else $error("wired interrupt set without enabled activation");
   chk_errmsg_silent: assert property (abort_reg[0] && ERR_NS_I == 6'h00 &&
      !FAILURE_ENTRY_I && !pend_reg[0] |=> !pend_reg[0] && !$rose(int_status_reg[0]))
      else $error("error message abort raised an interrupt");
   chk_msi_fields: assert property ($rose(MSI_NS_O.valid)
      |-> MSI_NS_O.addr == $past(cfg_reg[0][0]) && MSI_NS_O.data == $past(cfg_reg[0][1]) &&
          MSI_NS_O.attr == $past(cfg_reg[0][2]))
      else $error("message fields not taken from configuration");
   chk_msi_hold: assert property (MSI_S_O.valid && !MSI_DONE_I[1] |=> MSI_S_O.valid &&
      $stable(MSI_S_O.addr))
      else $error("message request dropped before completion");
   chk_apb_ready: assert property (setup |=> PREADY_O ##1 !PREADY_O)
      else $error("bus answer not one access cycle");
   chk_irq_level: assert property (IRQ_O == |(int_status_reg & int_mask_reg))
      else $error("interrupt output disagrees with status and mask");

   cov_failure_mode: cover property (FAILURE_ENTRY_I ##1 active[0][7] && active[1][7]);
   cov_msi_abort: cover property (MSI_NS_O.valid && MSI_DONE_I[0] && MSI_ABORT_I[0]
      ##2 active[0][ger_pkg::BIT_ERR_MSG]);
   cov_cmdq_ack: cover property ($rose(CMDQ_HALT_O[1]) ##[1:20] $fell(CMDQ_HALT_O[1]));
   cov_wired_irq: cover property ($rose(IRQ_O));

endmodule

`default_nettype wire

/* File: ger_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module ger_top_tb;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic MCLK_I = 1'b0;
   logic RESET_N_I = 1'b0;
   logic PSEL_I = 1'b0;
   logic PENABLE_I = 1'b0;
   logic PWRITE_I = 1'b0;
   logic [7:0] PADDR_I = 8'h00;
   logic [31:0] PWDATA_I = 32'h0000_0000;
   logic [31:0] PRDATA_O;
   logic PREADY_O;
   logic PSLVERR_O;
   ger_pkg::ger_err_t ERR_NS_I = '0;
   ger_pkg::ger_err_t ERR_S_I = '0;
   logic FAILURE_ENTRY_I = 1'b0;
   logic [1:0] CMDQ_HALT_O;
   logic [1:0] EVENTQ_HALT_O;
   logic [1:0] PRIQ_HALT_O;
   ger_pkg::ger_msi_t MSI_NS_O;
   ger_pkg::ger_msi_t MSI_S_O;
   logic [1:0] MSI_DONE_I = 2'b00;
   logic [1:0] MSI_ABORT_I = 2'b00;
   logic IRQ_O;
   logic [32:0] exp_q[$];
   logic [7:0] exp_flags[2] = '{8'h00, 8'h00};
   logic [7:0] exp_ack[2] = '{8'h00, 8'h00};
   int err_total = 0;
   int n_checks = 0;

   always #5 MCLK_I = ~MCLK_I;

   ger_top i_dut (
      .MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
      .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
      .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .ERR_NS_I(ERR_NS_I), .ERR_S_I(ERR_S_I),
      .FAILURE_ENTRY_I(FAILURE_ENTRY_I), .CMDQ_HALT_O(CMDQ_HALT_O), .EVENTQ_HALT_O(EVENTQ_HALT_O),
      .PRIQ_HALT_O(PRIQ_HALT_O), .MSI_NS_O(MSI_NS_O), .MSI_S_O(MSI_S_O),
      .MSI_DONE_I(MSI_DONE_I), .MSI_ABORT_I(MSI_ABORT_I), .IRQ_O(IRQ_O)
   );

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // The note is queued before the setup cycle so the monitor can never see an answer first.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] exp);
      int n;
      exp_q.push_back(exp);
      @(posedge MCLK_I);
      PSEL_I <= 1'b1;
      PENABLE_I <= 1'b0;
      PWRITE_I <= w;
      PADDR_I <= a;
      PWDATA_I <= d;
      @(posedge MCLK_I);
      PENABLE_I <= 1'b1;
      n = 0;
      do
      begin
         @(posedge MCLK_I);
         n++;
      end
      while (PREADY_O !== 1'b1 && n < 20);
      if (PREADY_O !== 1'b1)
         err_total++;
      PSEL_I <= 1'b0;
      PENABLE_I <= 1'b0;
   endtask

   function automatic logic [7:0] ad(input int bank, input logic [7:0] off);
      return off + (bank != 0 ? 8'h40 : 8'h00);
   endfunction

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000, {1'b0, e});
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, '0);
   endtask

   task automatic pulse(input int bank, input logic [7:0] v);
      @(posedge MCLK_I);
      if (bank == 0)
         ERR_NS_I <= ger_pkg::ger_err_t'(v[5:0]);
      else
         ERR_S_I <= ger_pkg::ger_err_t'(v[5:0]);
      FAILURE_ENTRY_I <= v[7];
      @(posedge MCLK_I);
      ERR_NS_I <= '0;
      ERR_S_I <= '0;
      FAILURE_ENTRY_I <= 1'b0;
      @(posedge MCLK_I);
      #1;
   endtask

   task automatic chk_halt(input int bank);
      logic [7:0] act;
      logic [2:0] halt;
      act = exp_flags[bank] ^ exp_ack[bank];
      halt = {PRIQ_HALT_O[bank], EVENTQ_HALT_O[bank], CMDQ_HALT_O[bank]};
      chk(33'(halt), 33'(act[2:0]));
   endtask

   task automatic ack(input int bank);
      wr(ad(bank, ger_pkg::OFF_ACK), {24'h00_0000, exp_flags[bank]});
      exp_ack[bank] = exp_flags[bank];
   endtask

   // ---------------------------------------------------------------
   // Result monitor
   // ---------------------------------------------------------------
   always @(posedge MCLK_I)
   begin
      if (PSEL_I === 1'b1 && PENABLE_I === 1'b1 && PREADY_O === 1'b1)
      begin
         if (exp_q.size() == 0)
            chk({PSLVERR_O, PRDATA_O}, 33'h1_ffff_ffff);
         else
            chk({PSLVERR_O, PRDATA_O}, exp_q.pop_front());
      end
   end

   initial
   begin
      #200us;
      err_total++;
      print_verdict();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      logic [7:0] impl;
      logic [31:0] cfg[3];
      ger_pkg::ger_msi_t m;
      int n;
      repeat (2) @(posedge MCLK_I);
      RESET_N_I <= 1'b1;
      void'($urandom(32'h7f21));
      for (int bk = 0; bk < 2; bk++)
      begin
         rd(ad(bk, ger_pkg::OFF_FLAGS), ger_pkg::RST_WORD);
         rd(ad(bk, ger_pkg::OFF_ACK), ger_pkg::RST_WORD);
         rd(ad(bk, ger_pkg::OFF_IRQ_CTRL), ger_pkg::RST_WORD);
         wr(ad(bk, ger_pkg::OFF_IRQ_CTRL), 32'h0000_0001);
      end
      apb(1'b0, 8'h3c, 32'h0000_0000, {1'b1, 32'h0000_0000});
      wr(ger_pkg::OFF_INT_MASK, 32'h0000_0003);
      // Two rounds so each implemented flag of bits 0 to 5 is toggled up and then back down, each toggle acknowledged.
      for (int r = 0; r < 2; r++)
         for (int bk = 0; bk < 2; bk++)
            for (int b = 0; b < 6; b++)
            begin
               impl = (bk != 0) ? ger_pkg::IMPL_MASK_S : ger_pkg::IMPL_MASK_NS;
               pulse(bk, 8'(1 << b));
               exp_flags[bk][b] = exp_flags[bk][b] ^ impl[b];
               chk_halt(bk);
               chk(33'(IRQ_O), 33'(impl[b]));
               rd(ad(bk, ger_pkg::OFF_FLAGS), {24'h00_0000, exp_flags[bk]});
               pulse(bk, 8'(1 << b));
               rd(ad(bk, ger_pkg::OFF_FLAGS), {24'h00_0000, exp_flags[bk]});
               rd(ger_pkg::OFF_INT_STATUS, 32'(impl[b]) << bk);
               wr(ad(bk, ger_pkg::OFF_FLAGS), 32'h0000_00ff);
               ack(bk);
               rd(ad(bk, ger_pkg::OFF_FLAGS), {24'h00_0000, exp_flags[bk]});
               #1;
               chk_halt(bk);
               chk(33'(IRQ_O), '0);
            end
      rd(ad(1, ger_pkg::OFF_ACK), {24'h00_0000, exp_ack[1]});
      pulse(0, 8'h80);
      exp_flags[0][7] = ~exp_flags[0][7];
      exp_flags[1][7] = ~exp_flags[1][7];
      for (int bk = 0; bk < 2; bk++)
         rd(ad(bk, ger_pkg::OFF_FLAGS), {24'h00_0000, exp_flags[bk]});
      rd(ger_pkg::OFF_INT_STATUS, 32'h0000_0003);
      ack(0);
      ack(1);
      wr(ad(0, ger_pkg::OFF_IRQ_CTRL), 32'h0000_0000);
      pulse(0, 8'h01);
      exp_flags[0][0] = ~exp_flags[0][0];
      chk_halt(0);
      chk(33'(IRQ_O), '0);
      rd(ger_pkg::OFF_INT_STATUS, 32'h0000_0000);
      ack(0);
      for (int bk = 0; bk < 2; bk++)
      begin
         for (int i = 0; i < 3; i++)
         begin
            cfg[i] = $urandom();
            wr(ad(bk, ger_pkg::OFF_CFG0 + 8'(4 * i)), cfg[i]);
         end
         wr(ad(bk, ger_pkg::OFF_IRQ_CTRL), 32'h0000_0003);
         pulse(bk, 8'h02);
         exp_flags[bk][1] = ~exp_flags[bk][1];
         n = 0;
         m = (bk != 0) ? MSI_S_O : MSI_NS_O;
         while (m.valid !== 1'b1 && n < 10)
         begin
            @(posedge MCLK_I);
            #1;
            m = (bk != 0) ? MSI_S_O : MSI_NS_O;
            n++;
         end
         chk(33'(m.valid), 33'h1);
         chk({1'b0, m.addr}, {1'b0, cfg[0]});
         chk({1'b0, m.data}, {1'b0, cfg[1]});
         chk({1'b0, m.attr}, {1'b0, cfg[2]});
         @(posedge MCLK_I);
         MSI_DONE_I[bk] <= 1'b1;
         MSI_ABORT_I[bk] <= 1'b1;
         @(posedge MCLK_I);
         MSI_DONE_I[bk] <= 1'b0;
         MSI_ABORT_I[bk] <= 1'b0;
         repeat (6) @(posedge MCLK_I);
         #1;
         exp_flags[bk][6] = ~exp_flags[bk][6];
         m = (bk != 0) ? MSI_S_O : MSI_NS_O;
         chk(33'(m.valid), '0);
         rd(ad(bk, ger_pkg::OFF_FLAGS), {24'h00_0000, exp_flags[bk]});
         chk_halt(bk);
         ack(bk);
         wr(ad(bk, ger_pkg::OFF_IRQ_CTRL), 32'h0000_0000);
      end
      repeat (3) @(posedge MCLK_I);
      print_verdict();
   end
endmodule

`default_nettype wire
